/* File: logic/iolsm_params.svh */
// constants for the control latch and sense module: offsets, fields, timing
// Behaviour
// RL1 - host waits while transfer controller busy
// RL2 - host initializes, loads addresses, then enables
// RL3 - control code 0 outputs, 1 inputs transfer
// RL4 - host checks abnormal stop after busy ends
// RL5 - channel select picks gated input 0/2/4/6
// RL6 - selection held until replaced at same address
// RL7 - input instruction returns selected gated word
// RL8 - control command code X sets latch X
// RL9 - commands only set; clear via reset input
// RL10 - wired latch output clears the next latch
// RL11 - wired reset latch clears all others
// RL12 - self-reset through external delay gives pulse
// RL13 - receiver may return reset over cable
// RL14 - grounded reset: latch follows command strobe
// RL15 - strobe never clears latch otherwise
// RL16 - handshake: device clears latch, sense sees it
// RL17 - sense command X returns line X level
// RL18 - host polls device ready sense line
// RL19 - transfer controllers use octal pairs 20-27
// RL20 - system clear drops channel selection
// RL21 - respond only at configured device address
`ifndef IOLSM_PARAMS_SVH
`define IOLSM_PARAMS_SVH

// register byte offsets
`define IOLSM_OFF_CMD 8'h00
`define IOLSM_OFF_CFG 8'h04
`define IOLSM_OFF_STATUS 8'h08
`define IOLSM_OFF_DATA 8'h0c

// command word fields
`define IOLSM_CMD_CODE_LSB 0
`define IOLSM_CMD_DEV_LSB 3
`define IOLSM_CMD_OP_LSB 10
// device address group: octal 5x
`define IOLSM_DEV_GROUP 3'h5

// config word fields and reset values
`define IOLSM_CFG_ADDR_LSB 0
`define IOLSM_CFG_FOLLOW_LSB 8
`define IOLSM_CFG_ADDR_RST 3'h0
`define IOLSM_CFG_FOLLOW_RST 8'h00

// status word fields
`define IOLSM_ST_SENSE_BIT 8
`define IOLSM_ST_SENSE_DONE 9
`define IOLSM_ST_SEL_LSB 10
`define IOLSM_ST_SEL_VALID 13
`define IOLSM_ST_BIC_OUT 14
`define IOLSM_ST_BIC_IN 15

// function codes that connect the transfer controller
`define IOLSM_CODE_BIC_OUT 3'h0
`define IOLSM_CODE_BIC_IN 3'h1

// axi responses
`define IOLSM_RESP_OKAY 2'h0
`define IOLSM_RESP_SLVERR 2'h2

// command strobe length
`define IOLSM_CLK_NS 100
`define IOLSM_STROBE_NS 200
`define IOLSM_STROBE_CYC ((`IOLSM_STROBE_NS + `IOLSM_CLK_NS - 1) / `IOLSM_CLK_NS)

`endif

/* File: logic/iolsm_pkg.sv */
// types shared by the control latch and sense module
`default_nettype none
package iolsm_pkg;

    // instruction kinds carried by a command write
    typedef enum logic [1:0] {
        IOLSM_OP_CONTROL = 2'b00,
        IOLSM_OP_SELECT = 2'b01,
        IOLSM_OP_SENSE = 2'b10,
        IOLSM_OP_INPUT = 2'b11
    } iolsm_op_type;

    // command sequencing phase
    typedef enum logic [1:0] {
        IOLSM_PH_IDLE = 2'b00,
        IOLSM_PH_STROBE = 2'b01
    } iolsm_phase_type;

    typedef struct packed {
        logic [7:0] q;
    } iolsm_bank_type;

    typedef struct packed {
        iolsm_phase_type phase;
        logic [1:0] strobe_cnt;
        logic [2:0] strobe_code;
        logic aw_held;
        logic [7:0] aw_addr;
        logic aw_bad;
        logic w_held;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [2:0] cfg_addr;
        logic [7:0] cfg_follow;
        logic sel_valid;
        logic [2:0] sel_code;
        logic sense_bit;
        logic sense_done;
        logic [15:0] in_word;
        logic bic_out;
        logic bic_in;
        logic [7:0] sense_s1;
        logic [7:0] sense_s2;
        logic [63:0] gated_s1;
        logic [63:0] gated_s2;
        logic [7:0] rst_s1;
        logic [7:0] rst_s2;
        logic clr_s1;
        logic clr_s2;
    } iolsm_core_type;

endpackage
`default_nettype wire

/* File: logic/iolsm_latch_if.sv */
// signals between the command logic and the control latch bank
`default_nettype none
interface iolsm_latch_if;
    logic [7:0] set_strobe;
    logic [7:0] follow;
    logic [7:0] reset_in;
    logic [7:0] q;

    modport ctrl (output set_strobe, output follow, output reset_in, input q);
    modport bank (input set_strobe, input follow, input reset_in, output q);
endinterface
`default_nettype wire

/* File: logic/iolsm_latch_bank.sv */
// eight control output latches, set by command strobe, cleared by reset inputs
`default_nettype none
module iolsm_latch_bank (
    input wire logic clk_i,
    input wire logic rst_i,
    iolsm_latch_if.bank lat
);
    iolsm_pkg::iolsm_bank_type s_r;
    iolsm_pkg::iolsm_bank_type s_nxt;

    // set wins; reset input clears; follow mode copies the strobe
    always_comb begin
        s_nxt = s_r;
        for (int i = 0; i < 8; i++) begin
            if (lat.follow[i]) begin
                s_nxt.q[i] = lat.set_strobe[i]; // [RL14]
            end else if (lat.set_strobe[i]) begin
                s_nxt.q[i] = 1'b1; // [RL8] [RL15]
            end else if (lat.reset_in[i]) begin
                s_nxt.q[i] = 1'b0; // [RL9] [RL10] [RL11] [RL12] [RL16]
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign lat.q = s_r.q;
endmodule
`default_nettype wire

/* File: logic/iolsm_top.sv */
// control latch, channel select and sense logic behind an axi4-lite slave
//
// Local design decisions: the register offsets and the AXI4-Lite slave port.
`include "iolsm_params.svh"
`default_nettype none
module iolsm_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [31:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [31:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic [7:0] sense_line_i,
    input wire logic [63:0] gated_input_i,
    input wire logic [7:0] control_latch_reset_input_i,
    input wire logic system_clear_i,
    output logic [7:0] control_latch_output_o,
    output logic bic_output_connect_o,
    output logic bic_input_connect_o,
    output logic [15:0] selected_word_o
);
    iolsm_pkg::iolsm_core_type s_r;
    iolsm_pkg::iolsm_core_type s_nxt;

    iolsm_latch_if lat ();

    iolsm_latch_bank u_bank (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .lat(lat)
    );

    // true when a command names this module's device address
    function automatic logic iolsm_addr_hit(input logic [5:0] dev, input logic [2:0] cfg);
        iolsm_addr_hit = (dev == {`IOLSM_DEV_GROUP, cfg});
    endfunction

    // merge one written word into a stored field by byte lanes
    function automatic logic [31:0] iolsm_merge(input logic [31:0] old,
                                                 input logic [31:0] val,
                                                 input logic [3:0] strb);
        logic [31:0] m;
        m = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                m[b*8 +: 8] = val[b*8 +: 8];
            end
        end
        iolsm_merge = m;
    endfunction

    // latch bank drive: strobe only during the strobe phase
    always_comb begin
        lat.set_strobe = '0;
        if (s_r.phase == iolsm_pkg::IOLSM_PH_STROBE) begin
            lat.set_strobe = 8'h01 << s_r.strobe_code; // [RL8]
        end
        lat.follow = s_r.cfg_follow;
        lat.reset_in = s_r.rst_s2;
    end

    // whole next state of the slave and command logic
    always_comb begin
        logic [31:0] cfg_word;
        logic [2:0] code;
        logic [5:0] dev;
        iolsm_pkg::iolsm_op_type op;
        logic hit;
        cfg_word = '0;
        code = '0;
        dev = '0;
        op = iolsm_pkg::IOLSM_OP_CONTROL;
        hit = 1'b0;
        s_nxt = s_r;

        // pin synchronisers, two stages each
        s_nxt.sense_s1 = sense_line_i;
        s_nxt.sense_s2 = s_r.sense_s1;
        s_nxt.gated_s1 = gated_input_i;
        s_nxt.gated_s2 = s_r.gated_s1;
        s_nxt.rst_s1 = control_latch_reset_input_i;
        s_nxt.rst_s2 = s_r.rst_s1;
        s_nxt.clr_s1 = system_clear_i;
        s_nxt.clr_s2 = s_r.clr_s1;

        // transfer controller connect follows latches 0 and 1
        s_nxt.bic_out = lat.q[`IOLSM_CODE_BIC_OUT]; // [RL3]
        s_nxt.bic_in = lat.q[`IOLSM_CODE_BIC_IN]; // [RL3]

        // strobe countdown
        if (s_r.phase == iolsm_pkg::IOLSM_PH_STROBE) begin
            if (s_r.strobe_cnt == 2'h1) begin
                s_nxt.phase = iolsm_pkg::IOLSM_PH_IDLE;
                s_nxt.strobe_cnt = '0;
            end else begin
                s_nxt.strobe_cnt = s_r.strobe_cnt - 2'h1;
            end
        end

        // write address and data captured in either order
        if (s_axi_awvalid_i && s_r.awready) begin
            s_nxt.aw_held = 1'b1;
            s_nxt.aw_addr = s_axi_awaddr_i[7:0];
            s_nxt.aw_bad = (s_axi_awaddr_i[31:8] != '0);
        end
        if (s_axi_wvalid_i && s_r.wready) begin
            s_nxt.w_held = 1'b1;
            s_nxt.wdata = s_axi_wdata_i;
            s_nxt.wstrb = s_axi_wstrb_i;
        end

        // response handshake
        if (s_r.bvalid && s_axi_bready_i) begin
            s_nxt.bvalid = 1'b0;
        end

        // execute a held write once both halves are in
        if (s_r.aw_held && s_r.w_held && !s_r.bvalid
            && s_r.phase == iolsm_pkg::IOLSM_PH_IDLE) begin
            s_nxt.aw_held = 1'b0;
            s_nxt.w_held = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = `IOLSM_RESP_OKAY;
            code = s_r.wdata[`IOLSM_CMD_CODE_LSB +: 3];
            dev = s_r.wdata[`IOLSM_CMD_DEV_LSB +: 6];
            op = iolsm_pkg::iolsm_op_type'(s_r.wdata[`IOLSM_CMD_OP_LSB +: 2]);
            hit = iolsm_addr_hit(dev, s_r.cfg_addr); // [RL21]
            if (s_r.aw_bad) begin
                s_nxt.bresp = `IOLSM_RESP_SLVERR;
            end else if (s_r.aw_addr == `IOLSM_OFF_CMD) begin
                if (hit) begin
                    unique case (op)
                        iolsm_pkg::IOLSM_OP_CONTROL: begin
                            s_nxt.phase = iolsm_pkg::IOLSM_PH_STROBE; // [RL3] [RL8]
                            s_nxt.strobe_cnt = 2'(`IOLSM_STROBE_CYC); // [RL14]
                            s_nxt.strobe_code = code;
                        end
                        iolsm_pkg::IOLSM_OP_SELECT: begin
                            s_nxt.sel_valid = 1'b1; // [RL5] [RL6]
                            s_nxt.sel_code = code;
                        end
                        iolsm_pkg::IOLSM_OP_SENSE: begin
                            s_nxt.sense_bit = s_r.sense_s2[code]; // [RL17] [RL16]
                            s_nxt.sense_done = 1'b1;
                        end
                        iolsm_pkg::IOLSM_OP_INPUT: begin
                            if (s_r.sel_valid && !s_r.sel_code[0]) begin
                                s_nxt.in_word =
                                    s_r.gated_s2[{s_r.sel_code[2:1], 4'h0} +: 16]; // [RL7]
                            end else begin
                                s_nxt.in_word = '0;
                            end
                        end
                    endcase
                end
            end else if (s_r.aw_addr == `IOLSM_OFF_CFG) begin
                cfg_word = iolsm_merge({16'h0, s_r.cfg_follow, 5'h0, s_r.cfg_addr},
                                       s_r.wdata, s_r.wstrb);
                s_nxt.cfg_addr = cfg_word[`IOLSM_CFG_ADDR_LSB +: 3];
                s_nxt.cfg_follow = cfg_word[`IOLSM_CFG_FOLLOW_LSB +: 8];
            end else begin
                s_nxt.bresp = `IOLSM_RESP_SLVERR;
            end
        end

        // system clear drops the channel selection
        if (s_r.clr_s2) begin
            s_nxt.sel_valid = 1'b0; // [RL20]
            s_nxt.sel_code = '0;
        end

        // write channel readiness: one write under way at a time
        s_nxt.awready = !s_nxt.aw_held && !s_nxt.bvalid
                        && s_nxt.phase == iolsm_pkg::IOLSM_PH_IDLE;
        s_nxt.wready = !s_nxt.w_held && !s_nxt.bvalid
                       && s_nxt.phase == iolsm_pkg::IOLSM_PH_IDLE;

        // read channel: take address, answer next cycle
        if (s_r.rvalid && s_axi_rready_i) begin
            s_nxt.rvalid = 1'b0;
            s_nxt.arready = 1'b1;
        end
        if (s_axi_arvalid_i && s_r.arready) begin
            s_nxt.arready = 1'b0;
            s_nxt.rvalid = 1'b1;
            s_nxt.rresp = `IOLSM_RESP_OKAY;
            s_nxt.rdata = '0;
            if (s_axi_araddr_i[31:8] != '0) begin
                s_nxt.rresp = `IOLSM_RESP_SLVERR;
            end else if (s_axi_araddr_i[7:0] == `IOLSM_OFF_CMD) begin
                s_nxt.rdata = '0;
            end else if (s_axi_araddr_i[7:0] == `IOLSM_OFF_CFG) begin
                s_nxt.rdata[`IOLSM_CFG_ADDR_LSB +: 3] = s_r.cfg_addr;
                s_nxt.rdata[`IOLSM_CFG_FOLLOW_LSB +: 8] = s_r.cfg_follow;
            end else if (s_axi_araddr_i[7:0] == `IOLSM_OFF_STATUS) begin
                s_nxt.rdata[7:0] = lat.q;
                s_nxt.rdata[`IOLSM_ST_SENSE_BIT] = s_r.sense_bit;
                s_nxt.rdata[`IOLSM_ST_SENSE_DONE] = s_r.sense_done;
                s_nxt.rdata[`IOLSM_ST_SEL_LSB +: 3] = s_r.sel_code;
                s_nxt.rdata[`IOLSM_ST_SEL_VALID] = s_r.sel_valid;
                s_nxt.rdata[`IOLSM_ST_BIC_OUT] = s_r.bic_out;
                s_nxt.rdata[`IOLSM_ST_BIC_IN] = s_r.bic_in;
            end else if (s_axi_araddr_i[7:0] == `IOLSM_OFF_DATA) begin
                s_nxt.rdata[15:0] = s_r.in_word;
            end else begin
                s_nxt.rresp = `IOLSM_RESP_SLVERR;
            end
        end
    end

    // state register with synchronous reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_r <= '0;
            s_r.awready <= 1'b1;
            s_r.wready <= 1'b1;
            s_r.arready <= 1'b1;
            s_r.cfg_addr <= `IOLSM_CFG_ADDR_RST;
            s_r.cfg_follow <= `IOLSM_CFG_FOLLOW_RST;
            s_r.phase <= iolsm_pkg::IOLSM_PH_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    // outputs straight from state flops
    assign s_axi_awready_o = s_r.awready;
    assign s_axi_wready_o = s_r.wready;
    assign s_axi_bvalid_o = s_r.bvalid;
    assign s_axi_bresp_o = s_r.bresp;
    assign s_axi_arready_o = s_r.arready;
    assign s_axi_rvalid_o = s_r.rvalid;
    assign s_axi_rresp_o = s_r.rresp;
    assign s_axi_rdata_o = s_r.rdata;
    assign control_latch_output_o = lat.q;
    assign bic_output_connect_o = s_r.bic_out;
    assign bic_input_connect_o = s_r.bic_in;
    assign selected_word_o = s_r.in_word;
endmodule
`default_nettype wire

/* File: test/iolsm_props.sv */
// port assertions for the control latch and sense module
`default_nettype none
module iolsm_props (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [31:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    input wire logic s_axi_awready_o,
    input wire logic s_axi_wvalid_i,
    input wire logic s_axi_wready_o,
    input wire logic [1:0] s_axi_bresp_o,
    input wire logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic s_axi_rvalid_o,
    input wire logic [7:0] control_latch_reset_input_i,
    input wire logic [7:0] control_latch_output_o,
    input wire logic bic_output_connect_o,
    input wire logic bic_input_connect_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] wr_age_r;
    logic [3:0] rs_age_r;
    logic bad_r;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // cycles since the last write address and the last reset input, saturating
    always_ff @(posedge clk_i) begin
        if (rst_i || (s_axi_awvalid_i && s_axi_awready_o)) wr_age_r <= 4'h0;
        else if (wr_age_r != 4'hf) wr_age_r <= wr_age_r + 4'h1;
        if (rst_i || (|control_latch_reset_input_i)) rs_age_r <= 4'h0;
        else if (rs_age_r != 4'hf) rs_age_r <= rs_age_r + 4'h1;
        if (s_axi_awvalid_i && s_axi_awready_o) begin
            bad_r <= (|s_axi_awaddr_i[31:4]) | (|s_axi_awaddr_i[1:0]) | s_axi_awaddr_i[3];
        end
    end
    sequence wr_taken;
        s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
    endsequence
    wr_answer_a: assert property (wr_taken |-> ##[1:4] s_axi_bvalid_o)
        else $error("write response missing");
    bvalid_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
        else $error("write response dropped");
    rd_answer_a: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
        else $error("read data late");
    bad_resp_a: assert property (s_axi_bvalid_o && bad_r |-> s_axi_bresp_o == 2'h2)
        else $error("bad write not refused");
    bic_out_a: assert property (bic_output_connect_o == $past(control_latch_output_o[0]))
        else $error("output connect wrong");
    bic_in_a: assert property (bic_input_connect_o == $past(control_latch_output_o[1]))
        else $error("input connect wrong");
    latch_rise_a: assert property (
        |(control_latch_output_o & ~$past(control_latch_output_o)) |-> wr_age_r <= 4'h8)
        else $error("latch set without command");
    latch_fall_a: assert property (
        |($past(control_latch_output_o) & ~control_latch_output_o)
            |-> rs_age_r <= 4'h6 || wr_age_r <= 4'h9)
        else $error("latch cleared without reset");
endmodule
bind iolsm_top iolsm_props chk (.clk_i, .rst_i, .s_axi_awaddr_i, .s_axi_awvalid_i,
    .s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o,
    .s_axi_bready_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rvalid_o,
    .control_latch_reset_input_i, .control_latch_output_o, .bic_output_connect_o,
    .bic_input_connect_o);
`default_nettype wire

/* File: test/iolsm_ext_model.sv */
// far side: latch reset wiring schemes and a handshaking device
`default_nettype none
module iolsm_ext_model (
    input wire logic clk_i,
    input wire logic [1:0] mode_i,
    input wire logic ack_i,
    input wire logic [7:0] latch_i,
    input wire logic [7:0] sense_src_i,
    output logic [7:0] sense_o,
    output logic [7:0] reset_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] dly;
    // delay element from the latch outputs back to their resets
    always_ff @(posedge clk_i) dly <= {dly[2:0], |latch_i};
    // reset wiring picked by the bench; mode 0 is a device that acknowledges
    always_comb begin
        sense_o = sense_src_i;
        case (mode_i)
            2'h0: begin
                reset_o = {8{ack_i}};
                sense_o[6] = latch_i[2];
            end
            2'h1: reset_o = {latch_i[0], latch_i[7:1]};
            2'h2: reset_o = {ack_i, {7{latch_i[7]}}};
            default: reset_o = {8{dly[3]}};
        endcase
    end
endmodule
`default_nettype wire

/* File: test/iolsm_top_tb_top.sv */
// self-checking bench for the control latch and sense module
`include "iolsm_params.svh"
`default_nettype none
module iolsm_top_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i, rst_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, ack;
    logic s_axi_arvalid_i, s_axi_rready_i, system_clear_i, s_axi_awready_o;
    logic s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
    logic bic_output_connect_o, bic_input_connect_o;
    logic [31:0] s_axi_awaddr_i, s_axi_wdata_i, s_axi_araddr_i, s_axi_rdata_o, d;
    logic [3:0] s_axi_wstrb_i;
    logic [1:0] s_axi_bresp_o, s_axi_rresp_o, r, mode;
    logic [7:0] sense_line_i, control_latch_reset_input_i, control_latch_output_o, ss;
    logic [63:0] gated_input_i;
    logic [15:0] selected_word_o;
    int miscompares, samples_checked, hc, h0, ls;
    iolsm_top uut (.clk_i, .rst_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o,
        .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o,
        .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i,
        .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i,
        .sense_line_i, .gated_input_i, .control_latch_reset_input_i, .system_clear_i,
        .control_latch_output_o, .bic_output_connect_o, .bic_input_connect_o,
        .selected_word_o);
    iolsm_ext_model ext (.clk_i, .mode_i(mode), .ack_i(ack), .latch_i(control_latch_output_o),
        .sense_src_i(ss), .sense_o(sense_line_i), .reset_o(control_latch_reset_input_i));
    // clock and a count of cycles the watched latch is high
    initial begin
        clk_i = 0;
        forever #50 clk_i = ~clk_i;
    end
    always @(posedge clk_i) if (control_latch_output_o[ls] === 1'b1) hc <= hc + 1;
    // expected gated word for a selected code
    function automatic logic [31:0] gw(input logic [63:0] g, input int c);
        return c[0] ? 32'h0 : {16'h0, g[16 * (c / 2) +: 16]};
    endfunction
    task automatic chk(input logic [31:0] got, exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // bus write: both channels offered, each dropped once taken
    task automatic wr(input logic [31:0] a, v);
        logic [2:0] t;
        @(posedge clk_i);
        s_axi_awaddr_i <= a;
        s_axi_wdata_i <= v;
        {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} <= 3'h7;
        t = 3'h0;
        while (!t[0]) begin
            @(negedge clk_i);
            t = {s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o};
            r = s_axi_bresp_o;
            @(posedge clk_i);
            if (t[2]) s_axi_awvalid_i <= 0;
            if (t[1]) s_axi_wvalid_i <= 0;
        end
        s_axi_bready_i <= 0;
    endtask
    task automatic rd(input logic [31:0] a);
        logic [1:0] t;
        @(posedge clk_i);
        s_axi_araddr_i <= a;
        {s_axi_arvalid_i, s_axi_rready_i} <= 2'h3;
        t = 2'h0;
        while (!t[0]) begin
            @(negedge clk_i);
            t = {s_axi_arready_o, s_axi_rvalid_o};
            d = s_axi_rdata_o;
            r = s_axi_rresp_o;
            @(posedge clk_i);
            if (t[1]) s_axi_arvalid_i <= 0;
        end
        s_axi_rready_i <= 0;
    endtask
    // command to any six-bit device address on the bus
    task automatic dev_cmd(input logic [1:0] op, input logic [5:0] dv, input logic [2:0] x);
        wr(32'h0, {20'h0, op, 1'b0, dv, x});
        chk(r, `IOLSM_RESP_OKAY);
    endtask
    task automatic cmd(input logic [1:0] op, input logic [2:0] n, x);
        dev_cmd(op, {3'h5, n}, x);
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // watchdog
    initial begin
        #2000000;
        miscompares++;
        report_and_stop;
    end
    // main sequence
    initial begin
        int i;
        int sq[4] = '{7, 0, 1, 2};
        logic [63:0] g;
        rst_i = 1;
        {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i} = 4'h0;
        {s_axi_rready_i, system_clear_i, ack, mode, ls} = 0;
        {s_axi_awaddr_i, s_axi_wdata_i, s_axi_araddr_i, ss, gated_input_i} = 0;
        s_axi_wstrb_i = 4'hf;
        void'($urandom(32'h4cc0d578));
        wt(5);
        rst_i <= 0;
        rd(32'h8);
        chk(d, 32'h0);
        rd(32'h10);
        chk(r, `IOLSM_RESP_SLVERR);
        wr(32'h8, 32'h0);
        chk(r, `IOLSM_RESP_SLVERR);
        wr(32'h4, 32'h3);
        cmd(2'h0, 3'h2, 3'h0);
        // transfer controller set-up at octal pair 20-21; this module must ignore it
        dev_cmd(2'h2, 6'h10, 3'h0);
        dev_cmd(2'h0, 6'h11, 3'h0);
        dev_cmd(2'h0, 6'h10, 3'h0);
        dev_cmd(2'h2, 6'h11, 3'h0);
        wt(6);
        rd(32'h8);
        chk(d[15:0], 16'h0);
        for (i = 0; i < 8; i++) begin
            cmd(2'h0, 3'h3, i[2:0]);
            wt(4);
            rd(32'h8);
            chk(d[7:0], (2 << i) - 1);
        end
        chk({bic_input_connect_o, bic_output_connect_o}, 2'h3);
        ack <= 1;
        wt(6);
        ack <= 0;
        wt(4);
        rd(32'h8);
        chk(d[15:0], 16'h0);
        $display("test latches done");
        mode <= 2'h1;
        for (i = 0; i < 4; i++) begin
            cmd(2'h0, 3'h3, sq[i][2:0]);
            wt(6);
            rd(32'h8);
            chk(d[7:0], 32'h1 << sq[i]);
        end
        mode <= 2'h2;
        cmd(2'h0, 3'h3, 3'h0);
        cmd(2'h0, 3'h3, 3'h1);
        wt(4);
        rd(32'h8);
        chk(d[7:0], 8'h07);
        cmd(2'h0, 3'h3, 3'h7);
        wt(6);
        rd(32'h8);
        chk(d[7:0], 8'h80);
        ss <= 8'($urandom);
        wt(4);
        for (i = 0; i < 8; i++) begin
            cmd(2'h2, 3'h3, i[2:0]);
            rd(32'h8);
            chk(d[9:8], {1'b1, ss[i]});
        end
        $display("test wiring done");
        mode <= 2'h0;
        ack <= 1;
        wt(6);
        ack <= 0;
        wt(4);
        cmd(2'h0, 3'h3, 3'h2);
        wt(6);
        cmd(2'h2, 3'h3, 3'h6);
        rd(32'h8);
        chk(d[9:8], 2'h3);
        ack <= 1;
        wt(6);
        ack <= 0;
        wt(4);
        cmd(2'h2, 3'h3, 3'h6);
        rd(32'h8);
        chk(d[9:0], 10'h200);
        wr(32'h4, 32'h2003);
        ls <= 5;
        h0 = hc;
        cmd(2'h0, 3'h3, 3'h5);
        wt(8);
        chk(hc - h0, `IOLSM_STROBE_CYC);
        wr(32'h4, 32'h3);
        mode <= 2'h3;
        ls <= 3;
        h0 = hc;
        cmd(2'h0, 3'h3, 3'h3);
        wt(20);
        rd(32'h8);
        chk(d[7:0], 8'h0);
        chk(hc - h0 >= 4, 1);
        $display("test pulses done");
        g = {$urandom, $urandom};
        gated_input_i <= g;
        wt(4);
        for (i = 0; i < 8; i += 2) begin
            cmd(2'h1, 3'h3, i[2:0]);
            cmd(2'h3, 3'h3, 3'h0);
            rd(32'hc);
            chk(d, gw(g, i));
            chk(selected_word_o, gw(g, i));
        end
        cmd(2'h1, 3'h2, 3'h0);
        cmd(2'h3, 3'h3, 3'h0);
        rd(32'hc);
        chk(d, gw(g, 6));
        rd(32'h8);
        chk(d[13:10], 4'he);
        cmd(2'h1, 3'h3, 3'h1);
        cmd(2'h3, 3'h3, 3'h0);
        rd(32'hc);
        chk(d, gw(g, 1));
        system_clear_i <= 1;
        wt(4);
        system_clear_i <= 0;
        wt(4);
        rd(32'h8);
        chk(d[13], 1'b0);
        $display("test select done");
        report_and_stop;
    end
endmodule
`default_nettype wire
